// *** core/hfmas_pkg.sv ***
// Package for the frame monitor alert and status block
package hfmas_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses on the 32-bit bus)
   // ------------------------------------------------------------
   localparam logic [7:0] ALERT_FLAGS_OFS = 8'h80;
   localparam logic [7:0] EDGE_SEL_OFS = 8'h84;
   localparam logic [7:0] THRESH_OFS = 8'h88;
   localparam logic [15:0] ALERT_FLAGS_RST = 16'h0020;

   // ------------------------------------------------------------
   // Field positions inside modem_alert_flags
   // ------------------------------------------------------------
   localparam int PHASE_LSB = 13;
   localparam int FRAME_END_BIT = 12;
   localparam int HDR_LEN_BIT = 11;
   localparam int HDR_CMD_BIT = 10;
   localparam int FRAME_START_BIT = 9;
   localparam int CARRIER_BIT = 8;
   localparam int CARRIER_EDGE_BIT = 7;
   localparam int TX_DONE_BIT = 6;
   localparam int TX_LEVEL_BIT = 5;
   localparam int RX_LEVEL_BIT = 4;
   localparam int RX_OVERRUN_BIT = 3;
   localparam int STOP_FAULT_BIT = 2;
   localparam int PARITY_FAULT_BIT = 1;
   localparam int GAP_FAULT_BIT = 0;
   // Write-one-to-clear bits
   localparam logic [15:0] W1C_MASK = 16'h1ecf;

   // ------------------------------------------------------------
   // Reset values and frame constants
   // ------------------------------------------------------------
   localparam logic [4:0] TX_THRESH_RST = 5'h08;
   localparam logic [4:0] RX_THRESH_RST = 5'h01;
   localparam logic [1:0] EDGE_SEL_RST = 2'h0;
   localparam logic [7:0] PREAMBLE_BYTE = 8'hff;
   localparam logic [2:0] MIN_PREAMBLES = 3'h2;
   localparam logic [7:0] LONG_ADDR_MASK = 8'h80;
   localparam logic [7:0] EXP_CNT_MASK = 8'h60;
   localparam logic [2:0] SHORT_ADDR_LEN = 3'h1;
   localparam logic [2:0] LONG_ADDR_LEN = 3'h5;

   // Receive phase codes
   typedef enum logic [2:0] {
      st_preamble,
      st_address,
      st_expansion,
      st_command,
      st_length,
      st_payload,
      st_checksum
   } hfmas_phase_t;

   // Carrier edge choice
   typedef enum logic [1:0] {
      edge_rise,
      edge_fall,
      edge_any
   } hfmas_edge_t;

   // One received character from the UART receiver
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic parity_err;
      logic stop_err;
      logic gap_err;
   } hfmas_rx_char_t;

   // Avalon-MM request
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } hfmas_av_req_t;

endpackage

// *** core/hfmas_alert_status.sv ***
// Frame monitor, alert flags and their Avalon-MM register port
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Report receive phase as 3-bit code
// - Write one clears a sticky flag
// - Frame end flag after check byte
// - Gap or length-byte error suppresses frame end
// - Header-to-length flag after length byte
// - Gap or length-byte error withholds it
// - Header-to-command flag; only gap blocks
// - Frame start: two clean preambles, delimiter
// - Live carrier detect, read-only status
// - Carrier edge flag on selected edge
// - New edge selection applies next edge
// - Tx done: last bit, FIFO empty
// - Tx level flag: occupancy at/below threshold
// - Tx level reads one after reset
// - Rx level flag: threshold reached
// - Byte into full rx FIFO sets overrun
// - Framing error sets stop-bit fault
// - Parity mismatch sets parity fault
// - Character gap sets gap fault
// - Gap fault at frame end optional
module hfmas_alert_status (
   input wire logic core_clk,
   input wire logic srst,
   input wire hfmas_pkg::hfmas_av_req_t av_req,
   output logic av_waitrequest,
   output logic av_readdatavalid,
   output logic [31:0] av_readdata,
   output logic [1:0] av_response,
   input wire hfmas_pkg::hfmas_rx_char_t rx_char,
   input wire logic rx_fifo_full,
   input wire logic [4:0] rx_fifo_level,
   input wire logic [4:0] tx_fifo_level,
   input wire logic tx_last_bit_done,
   input wire logic carrier_detect,
   output logic [2:0] frame_monitor_phase,
   output logic [4:0] rx_threshold,
   output logic [4:0] transmit_threshold
);
   import hfmas_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   hfmas_phase_t phase_ff;
   logic [15:0] flags_ff;
   logic [1:0] edge_sel_ff;
   logic [4:0] tx_thresh_ff;
   logic [4:0] rx_thresh_ff;
   logic carrier_ff;
   logic [2:0] pre_cnt_ff;
   logic pre_clean_ff;
   logic [2:0] byte_cnt_ff;
   logic [1:0] exp_left_ff;
   logic [7:0] data_left_ff;
   logic gap_seen_ff;
   logic len_bad_ff;
   logic busy_ff;
   logic [31:0] rdata_ff;
   logic [1:0] resp_ff;

   // Bus decode and event strobes
   logic wr_hit;
   logic [15:0] clr_bits;
   logic [15:0] set_bits;
   logic ch_ok;
   logic carrier_rise;
   logic carrier_fall;
   logic edge_hit;
   logic end_frame;
   logic hdr_cmd_done;
   logic hdr_len_done;

   // Address lookup shared by read and write paths
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ALERT_FLAGS_OFS) || (a == EDGE_SEL_OFS) || (a == THRESH_OFS);
   endfunction

   // Number of address bytes from the delimiter
   function automatic logic [2:0] addr_len(input logic [7:0] d);
      addr_len = ((d & LONG_ADDR_MASK) != 8'h00) ? LONG_ADDR_LEN : SHORT_ADDR_LEN;
   endfunction

   // ------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, then answer
   // ------------------------------------------------------------
   assign wr_hit = av_req.write && busy_ff;
   assign clr_bits = (wr_hit && av_req.address == ALERT_FLAGS_OFS) ?
                     (av_req.writedata[15:0] & W1C_MASK) : 16'h0000;

   // Waitrequest drops for exactly one cycle per request
   always_ff @(posedge core_clk) begin
      if (srst) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (av_req.read || av_req.write) && !busy_ff;
      end
   end

   // Read data and response captured in the wait cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_ff <= 32'h0000_0000;
         resp_ff <= 2'h0;
      end else if ((av_req.read || av_req.write) && !busy_ff) begin
         resp_ff <= mapped(av_req.address) ? 2'h0 : 2'h2;
         if (!av_req.read) begin
            rdata_ff <= 32'h0000_0000;
         end else if (av_req.address == ALERT_FLAGS_OFS) begin
            rdata_ff <= {16'h0000, phase_ff, flags_ff[12:9], carrier_ff, flags_ff[7:0]};
         end else if (av_req.address == EDGE_SEL_OFS) begin
            rdata_ff <= {30'h0000_0000, edge_sel_ff};
         end else if (av_req.address == THRESH_OFS) begin
            rdata_ff <= {19'h0_0000, rx_thresh_ff, 3'h0, tx_thresh_ff};
         end else begin
            rdata_ff <= 32'h0000_0000;
         end
      end
   end

   assign av_waitrequest = !busy_ff;
   assign av_readdatavalid = busy_ff && av_req.read;
   assign av_readdata = rdata_ff;
   assign av_response = resp_ff;

   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         edge_sel_ff <= EDGE_SEL_RST;
         tx_thresh_ff <= TX_THRESH_RST;
         rx_thresh_ff <= RX_THRESH_RST;
      end else if (wr_hit && av_req.address == EDGE_SEL_OFS) begin
         edge_sel_ff <= av_req.writedata[1:0];
      end else if (wr_hit && av_req.address == THRESH_OFS) begin
         tx_thresh_ff <= av_req.writedata[4:0];
         rx_thresh_ff <= av_req.writedata[12:8];
      end
   end

   // ------------------------------------------------------------
   // Carrier detect edges
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         carrier_ff <= 1'b0;
      end else begin
         carrier_ff <= carrier_detect;
      end
   end

   assign carrier_rise = carrier_detect && !carrier_ff;
   assign carrier_fall = !carrier_detect && carrier_ff;
   // Selection is read live, so the next edge after a change counts
   assign edge_hit = (edge_sel_ff == edge_rise) ? carrier_rise :
                     (edge_sel_ff == edge_fall) ? carrier_fall :
                     (edge_sel_ff == edge_any) ? (carrier_rise || carrier_fall) : 1'b0;

   // ------------------------------------------------------------
   // Frame monitor
   // ------------------------------------------------------------
   assign ch_ok = !rx_char.parity_err && !rx_char.stop_err;
   assign end_frame = rx_char.valid && phase_ff == st_checksum;
   assign hdr_cmd_done = rx_char.valid && phase_ff == st_command && !rx_char.gap_err && !gap_seen_ff;
   assign hdr_len_done = rx_char.valid && phase_ff == st_length && !rx_char.gap_err && !gap_seen_ff && ch_ok;

   // Phase walk through one frame
   always_ff @(posedge core_clk) begin
      if (srst) begin
         phase_ff <= st_preamble;
         pre_cnt_ff <= 3'h0;
         pre_clean_ff <= 1'b1;
         byte_cnt_ff <= 3'h0;
         exp_left_ff <= 2'h0;
         data_left_ff <= 8'h00;
      end else if (rx_char.valid && rx_char.gap_err) begin
         phase_ff <= st_preamble;
         pre_cnt_ff <= (rx_char.data == PREAMBLE_BYTE && ch_ok) ? 3'h1 : 3'h0;
         pre_clean_ff <= 1'b1;
      end else if (rx_char.valid) begin
         unique case (phase_ff)
            st_preamble: begin
               if (rx_char.data == PREAMBLE_BYTE) begin
                  pre_clean_ff <= pre_clean_ff && ch_ok && !rx_char.gap_err;
                  if (pre_cnt_ff != 3'h7) begin
                     pre_cnt_ff <= pre_cnt_ff + 3'h1;
                  end
               end else if (pre_cnt_ff >= MIN_PREAMBLES) begin
                  phase_ff <= st_address;
                  byte_cnt_ff <= addr_len(rx_char.data);
                  exp_left_ff <= 2'((rx_char.data & EXP_CNT_MASK) >> 5);
                  pre_cnt_ff <= 3'h0;
               end else begin
                  pre_cnt_ff <= 3'h0;
                  pre_clean_ff <= 1'b1;
               end
            end
            st_address: begin
               byte_cnt_ff <= byte_cnt_ff - 3'h1;
               if (byte_cnt_ff == 3'h1) begin
                  phase_ff <= (exp_left_ff != 2'h0) ? st_expansion : st_command;
               end
            end
            st_expansion: begin
               exp_left_ff <= exp_left_ff - 2'h1;
               if (exp_left_ff == 2'h1) begin
                  phase_ff <= st_command;
               end
            end
            st_command: begin
               phase_ff <= st_length;
            end
            st_length: begin
               data_left_ff <= rx_char.data;
               phase_ff <= (rx_char.data == 8'h00) ? st_checksum : st_payload;
            end
            st_payload: begin
               data_left_ff <= data_left_ff - 8'h01;
               if (data_left_ff == 8'h01) begin
                  phase_ff <= st_checksum;
               end
            end
            st_checksum: begin
               phase_ff <= st_preamble;
               pre_cnt_ff <= 3'h0;
               pre_clean_ff <= 1'b1;
            end
            default: begin
               phase_ff <= st_preamble;
            end
         endcase
      end
   end

   // Per-frame error memory for the header and end flags
   always_ff @(posedge core_clk) begin
      if (srst) begin
         gap_seen_ff <= 1'b0;
         len_bad_ff <= 1'b0;
      end else if (rx_char.valid && phase_ff == st_preamble) begin
         gap_seen_ff <= 1'b0;
         len_bad_ff <= 1'b0;
      end else if (rx_char.valid) begin
         gap_seen_ff <= gap_seen_ff || rx_char.gap_err;
         if (phase_ff == st_length) begin
            len_bad_ff <= !ch_ok;
         end
      end
   end

   // ------------------------------------------------------------
   // Sticky flags: set beats clear
   // ------------------------------------------------------------
   always_comb begin
      set_bits = 16'h0000;
      set_bits[FRAME_END_BIT] = end_frame && !gap_seen_ff && !rx_char.gap_err && !len_bad_ff;
      set_bits[HDR_LEN_BIT] = hdr_len_done;
      set_bits[HDR_CMD_BIT] = hdr_cmd_done;
      set_bits[FRAME_START_BIT] = rx_char.valid && phase_ff == st_preamble &&
                                  rx_char.data != PREAMBLE_BYTE && pre_cnt_ff >= MIN_PREAMBLES &&
                                  pre_clean_ff && ch_ok && !rx_char.gap_err;
      set_bits[CARRIER_EDGE_BIT] = edge_hit;
      set_bits[TX_DONE_BIT] = tx_last_bit_done && tx_fifo_level == 5'h00;
      set_bits[RX_OVERRUN_BIT] = rx_char.valid && rx_fifo_full;
      set_bits[STOP_FAULT_BIT] = rx_char.valid && rx_char.stop_err;
      set_bits[PARITY_FAULT_BIT] = rx_char.valid && rx_char.parity_err;
      set_bits[GAP_FAULT_BIT] = rx_char.valid && rx_char.gap_err;
   end

   // W1C bits hold until cleared; level bits follow their source
   always_ff @(posedge core_clk) begin
      if (srst) begin
         flags_ff <= ALERT_FLAGS_RST;
      end else begin
         flags_ff <= ((flags_ff & ~clr_bits) | set_bits) & W1C_MASK;
         flags_ff[TX_LEVEL_BIT] <= tx_fifo_level <= tx_thresh_ff;
         flags_ff[RX_LEVEL_BIT] <= rx_fifo_level >= rx_thresh_ff;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign frame_monitor_phase = phase_ff;
   assign rx_threshold = rx_thresh_ff;
   assign transmit_threshold = tx_thresh_ff;

endmodule

`default_nettype wire

// *** sim/hfmas_rx_model.sv ***
// HART line partner that hands received characters to the block
`timescale 1ns/100ps
`default_nettype none
module hfmas_rx_model (
   input wire logic core_clk,
   output var hfmas_pkg::hfmas_rx_char_t rx_char
);
   import hfmas_pkg::*;
   initial rx_char = '0;
   // One character, then idle with inverted data
   task automatic send(input logic [7:0] d, input logic [2:0] e);
      if (e[0]) repeat (20) @(posedge core_clk); // Long silence first
      @(posedge core_clk);
      rx_char <= '{1'b1, d, e[2], e[1], e[0]};
      @(posedge core_clk);
      rx_char <= '{1'b0, ~d, 1'b0, 1'b0, 1'b0};
      repeat (3) @(posedge core_clk);
   endtask
   // Short-address frame; byte pos carries e, cut after n bytes
   task automatic frame(input int pos, input logic [2:0] e, input int n);
      logic [7:0] b [8];
      b = '{8'hff, 8'hff, 8'h02, 8'h01, 8'h05, 8'h01, 8'haa, 8'h55}; // Two preambles
      for (int i = 0; i < n; i++) send(b[i], (i == pos) ? e : 3'h0);
   endtask
endmodule
`default_nettype wire

// *** sim/hfmas_alert_status_sva.sv ***
// Checker on the ports of the alert status block
`timescale 1ns/100ps
`default_nettype none
module hfmas_alert_status_sva (
   input wire logic core_clk,
   input wire logic srst,
   input wire hfmas_pkg::hfmas_av_req_t av_req,
   input wire logic av_waitrequest,
   input wire logic av_readdatavalid,
   input wire logic [31:0] av_readdata,
   input wire logic [1:0] av_response,
   input wire hfmas_pkg::hfmas_rx_char_t rx_char,
   input wire logic [2:0] frame_monitor_phase,
   input wire logic [4:0] transmit_threshold
);
   import hfmas_pkg::*;
   logic acc;
   logic unm;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   // Accept cycle and unmapped address decode
   assign acc = !av_waitrequest && (av_req.read || av_req.write);
   assign unm = av_req.address != ALERT_FLAGS_OFS && av_req.address != EDGE_SEL_OFS
      && av_req.address != THRESH_OFS;
   sequence s_take;
      (av_req.read || av_req.write) && av_waitrequest;
   endsequence
   sequence s_done;
      !av_waitrequest;
   endsequence
   wait_one_a: assert property (s_take |=> s_done)
      else $error("request not answered after one wait");
   rdv_read_a: assert property (av_readdatavalid |-> av_req.read && !av_waitrequest)
      else $error("read data valid without accepted read");
   unmapped_err_a: assert property (acc && av_req.read && unm |-> av_response == 2'b10 && av_readdata == 32'h0)
      else $error("unmapped read not refused");
   mapped_ok_a: assert property (acc && !unm |-> av_response == 2'b00)
      else $error("mapped access refused");
   thr_hold_a: assert property ($changed(transmit_threshold) |-> $past(acc && av_req.write && av_req.address == THRESH_OFS))
      else $error("threshold changed without a write");
   thr_reset_a: assert property ($fell(srst) |-> transmit_threshold == TX_THRESH_RST)
      else $error("threshold reset value wrong");
   phase_code_a: assert property (frame_monitor_phase != 3'h7)
      else $error("phase code out of range");
   phase_still_a: assert property (!rx_char.valid |=> $stable(frame_monitor_phase))
      else $error("phase moved without a character");
   chk_end_a: assert property (rx_char.valid && frame_monitor_phase == st_checksum |=> frame_monitor_phase == st_preamble)
      else $error("no return to preamble after check byte");
   gap_end_a: assert property (rx_char.valid && rx_char.gap_err |=> frame_monitor_phase == st_preamble)
      else $error("no return to preamble after gap");
endmodule
bind hfmas_alert_status hfmas_alert_status_sva u_sva (.core_clk, .srst, .av_req, .av_waitrequest, .av_readdatavalid,
   .av_readdata, .av_response, .rx_char, .frame_monitor_phase, .transmit_threshold);
`default_nettype wire

// *** sim/hfmas_alert_status_tb_top.sv ***
// Self-checking testbench for the alert status block
`timescale 1ns/100ps
`default_nettype none
module hfmas_alert_status_tb_top;
   import hfmas_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   hfmas_av_req_t av_req = '0;
   logic rx_fifo_full = 1'b0;
   logic [4:0] rx_fifo_level = 5'h00;
   logic [4:0] tx_fifo_level = 5'h00;
   logic tx_last_bit_done = 1'b0;
   logic carrier_detect = 1'b0;
   logic av_waitrequest, av_readdatavalid;
   logic [31:0] av_readdata, q;
   logic [1:0] av_response, rsp;
   logic rdv;
   logic [2:0] phase;
   logic [4:0] rx_thr, tx_thr;
   hfmas_rx_char_t rx_char;
   int miscompares = 0;
   int tests_run = 0;
   // Clock, 4 ns period
   always #2 core_clk = ~core_clk;
   hfmas_alert_status uut (.core_clk(core_clk), .srst(srst), .av_req(av_req), .av_waitrequest(av_waitrequest),
      .av_readdatavalid(av_readdatavalid), .av_readdata(av_readdata), .av_response(av_response),
      .rx_char(rx_char), .rx_fifo_full(rx_fifo_full), .rx_fifo_level(rx_fifo_level),
      .tx_fifo_level(tx_fifo_level), .tx_last_bit_done(tx_last_bit_done), .carrier_detect(carrier_detect),
      .frame_monitor_phase(phase), .rx_threshold(rx_thr), .transmit_threshold(tx_thr));
   hfmas_rx_model um (.core_clk(core_clk), .rx_char(rx_char));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      av_req <= '{!w, w, a, d};
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (av_waitrequest === 1'b0) break;
      end
      if (n == 50) begin
         miscompares++;
         end_of_test;
      end
      q = av_readdata;
      rsp = av_response;
      rdv = av_readdatavalid;
      av_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      repeat (4) @(posedge core_clk);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
      chk({31'h0, rdv}, 32'h1);
   endtask
   task automatic clr;
      bus(1'b1, ALERT_FLAGS_OFS, 32'hffff);
   endtask
   task automatic pulse;
      @(posedge core_clk);
      tx_last_bit_done <= 1'b1;
      @(posedge core_clk);
      tx_last_bit_done <= 1'b0;
   endtask
   task automatic t_reset;
      rd(ALERT_FLAGS_OFS, 32'h0020);
      rd(THRESH_OFS, 32'h0108);
      chk({27'h0, tx_thr}, 32'h8);
      chk({27'h0, rx_thr}, 32'h1);
      rd(8'h90, 32'h0);
      chk({30'h0, rsp}, 32'h2);
   endtask
   task automatic t_frame;
      um.frame(0, 3'h0, 8);
      rd(ALERT_FLAGS_OFS, 32'h1e20);
      chk({29'h0, phase}, 32'h0);
      bus(1'b1, ALERT_FLAGS_OFS, 32'h0);
      rd(ALERT_FLAGS_OFS, 32'h1e20);
      bus(1'b1, ALERT_FLAGS_OFS, 32'h1000);
      rd(ALERT_FLAGS_OFS, 32'h0e20);
      clr;
   endtask
   task automatic t_errs;
      int pos [6] = '{0, 2, 3, 5, 6, 4};
      logic [2:0] er [6] = '{3'h4, 3'h2, 3'h2, 3'h4, 3'h2, 3'h1};
      int nb [6] = '{8, 8, 8, 8, 8, 5};
      logic [15:0] ex [6] = '{16'h1c22, 16'h1c24, 16'h1e24, 16'h0622, 16'h1e24, 16'h0221};
      for (int i = 0; i < 6; i++) begin
         um.frame(pos[i], er[i], nb[i]);
         rd(ALERT_FLAGS_OFS, {16'h0, ex[i]});
         chk({29'h0, phase}, 32'h0);
         clr;
      end
   endtask
   task automatic t_tx;
      tx_fifo_level <= 5'h09;
      rd(ALERT_FLAGS_OFS, 32'h0000);
      tx_fifo_level <= 5'h08;
      pulse;
      rd(ALERT_FLAGS_OFS, 32'h0020);
      tx_fifo_level <= 5'h00;
      pulse;
      rd(ALERT_FLAGS_OFS, 32'h0060);
      clr;
      bus(1'b1, THRESH_OFS, 32'h0100);
      tx_fifo_level <= 5'h01;
      rd(ALERT_FLAGS_OFS, 32'h0000);
      tx_fifo_level <= 5'h00;
      rd(ALERT_FLAGS_OFS, 32'h0020);
      bus(1'b1, THRESH_OFS, 32'h010c);
   endtask
   task automatic t_rx;
      rx_fifo_level <= 5'h01;
      rd(ALERT_FLAGS_OFS, 32'h0030);
      rx_fifo_level <= 5'h00;
      rx_fifo_full <= 1'b1;
      um.send(8'hff, 3'h0);
      rx_fifo_full <= 1'b0;
      rd(ALERT_FLAGS_OFS, 32'h0028);
      clr;
   endtask
   task automatic t_cd;
      carrier_detect <= 1'b1;
      rd(ALERT_FLAGS_OFS, 32'h01a0);
      clr;
      rd(ALERT_FLAGS_OFS, 32'h0120);
      bus(1'b1, EDGE_SEL_OFS, 32'h1);
      carrier_detect <= 1'b0;
      rd(ALERT_FLAGS_OFS, 32'h00a0);
      bus(1'b1, EDGE_SEL_OFS, 32'h2);
      clr;
      carrier_detect <= 1'b1;
      rd(ALERT_FLAGS_OFS, 32'h01a0);
      clr;
      carrier_detect <= 1'b0;
      rd(ALERT_FLAGS_OFS, 32'h00a0);
      clr;
   endtask
   task automatic t_rst2;
      um.frame(0, 3'h0, 5);
      chk({29'h0, phase}, {29'h0, st_length});
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      rd(ALERT_FLAGS_OFS, 32'h0020);
      rd(THRESH_OFS, 32'h0108);
      chk({29'h0, phase}, 32'h0);
   endtask
   task automatic end_of_test;
      $display("counts: checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      t_reset;
      t_frame;
      t_errs;
      t_tx;
      t_rx;
      t_cd;
      t_rst2;
      end_of_test;
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      end_of_test;
   end
endmodule
`default_nettype wire
